// ===== src/dual_output_latch_sync.sv
`default_nettype none
// Summary of operation
// R1: each of the two channels can be set high-impedance on its own.
// R2: a high-impedance channel drops its output enable and leaves the line alone.
// R3: frame mode applies new outputs once a valid frame has passed.
// R4: frame mode needs no local timing setting; only frames pace updates.
// R5: sync mode captures frame data, applies it only on the sync pulse.
// R6: sync mode update period comes from the local clock, not frame jitter.
// R7: master sets the sync period equal to the supplying task cycle.
// R8: with two tasks, master picks the faster task period.
// R9: sync pulse is delayed by a configurable additive shift.
// R10: one shift applies to both channels; no per-channel shift.
// R11: configuring party builds the shift from free value, cycles, input reference.
// R12: shift and period settings are taken unchecked.
// R13: master must support distributed clocks for sync mode.
// R14: mode comes from a stored configuration, rewritten by the outside party.
// R15: mode change takes effect only after a restart.
// R16: after reset frame mode unless stored sync; outputs driven low.
module dual_output_latch_sync #(
    parameter int CH = 2
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // stored configuration strap, from nonvolatile memory
    input  wire logic          stored_mode_sync,
    // process data from the slave controller (same clock)
    input  wire logic          frame_valid,
    input  wire logic [CH-1:0] frame_out,
    input  wire logic [CH-1:0] frame_hiz,
    // output stage
    output logic      [CH-1:0] pin_o,
    output logic      [CH-1:0] pin_oe,
    output logic               sync_pulse,
    output logic               restart_req,
    // axi4-lite write address
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]    s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // axi4-lite read data
    output logic      [31:0]   s_axi_rdata,
    output logic      [1:0]    s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);
    logic                 strap_done_ff;
    logic                 mode_ff;
    logic                 stored_sel_ff;
    logic [31:0]          period_ff;
    logic [31:0]          shift_ff;
    logic [CH-1:0]        cap_out_ff;
    logic [CH-1:0]        cap_hiz_ff;
    logic [CH-1:0]        out_ff;
    logic [CH-1:0]        hiz_ff;
    logic [31:0]          cyc_cnt_ff;
    logic [31:0]          dly_cnt_ff;
    logic                 dly_run_ff;
    logic                 sync_ff;
    logic                 restart_ff;
    logic                 aw_hold_ff;
    logic                 w_hold_ff;
    logic [7:0]           awaddr_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           wstrb_ff;
    logic                 bvalid_ff;
    logic [1:0]           bresp_ff;
    logic                 rvalid_ff;
    logic [31:0]          rdata_ff;
    logic [1:0]           rresp_ff;
    logic                 wr_fire;
    logic                 cyc_wrap;

    // strap is caught once after reset release, never under reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_ff <= 1'b0;
            mode_ff       <= out_latch_pkg::MODE_FRAME;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            mode_ff       <= stored_mode_sync;          // [R14] [R16]
        end
    end

    // software view of the stored selection; only a restart makes it live
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stored_sel_ff <= out_latch_pkg::MODE_FRAME;
        end else if (!strap_done_ff) begin
            stored_sel_ff <= stored_mode_sync;
        end else if (wr_fire && awaddr_ff == out_latch_pkg::CTRL_OFF && wstrb_ff[0]) begin
            stored_sel_ff <= wdata_ff[out_latch_pkg::MODE_BIT];  // [R15]
        end
    end

    // restart request pulse: new mode waits for the restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= wr_fire && awaddr_ff == out_latch_pkg::CTRL_OFF && wstrb_ff[0]
                          && wdata_ff[out_latch_pkg::RESTART_BIT];  // [R15]
        end
    end

    // timing settings, stored as written on full-strobe writes only, without range checks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_ff <= out_latch_pkg::PERIOD_RST;
            shift_ff  <= out_latch_pkg::SHIFT_RST;
        end else if (wr_fire && &wstrb_ff) begin
            if (awaddr_ff == out_latch_pkg::PERIOD_OFF) begin
                period_ff <= wdata_ff;                  // [R12]
            end
            if (awaddr_ff == out_latch_pkg::SHIFT_OFF) begin
                shift_ff <= wdata_ff;                   // [R12] [R10]
            end
        end
    end

    // free-running local cycle; frames never touch it, so no jitter
    assign cyc_wrap = (cyc_cnt_ff >= period_ff - 32'h0000_0001);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt_ff <= 32'h0000_0000;
        end else if (cyc_wrap) begin
            cyc_cnt_ff <= 32'h0000_0000;                // [R6]
        end else begin
            cyc_cnt_ff <= cyc_cnt_ff + 32'h0000_0001;
        end
    end

    // shift delays the pulse after each cycle start; a shift beyond the
    // period restarts the delay, which is the unchecked-setting hazard
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dly_cnt_ff <= 32'h0000_0000;
            dly_run_ff <= 1'b0;
            sync_ff    <= 1'b0;
        end else begin
            sync_ff <= 1'b0;
            if (cyc_wrap) begin
                dly_cnt_ff <= shift_ff;                 // [R9]
                dly_run_ff <= 1'b1;
            end else if (dly_run_ff) begin
                if (dly_cnt_ff == 32'h0000_0000) begin
                    dly_run_ff <= 1'b0;
                    sync_ff    <= 1'b1;                 // [R9] [R10]
                end else begin
                    dly_cnt_ff <= dly_cnt_ff - 32'h0000_0001;
                end
            end
        end
    end
    assign sync_pulse = sync_ff;

    // capture from valid frames in either mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_out_ff <= out_latch_pkg::OUT_RST;
            cap_hiz_ff <= out_latch_pkg::HIZ_RST;
        end else if (frame_valid) begin
            cap_out_ff <= frame_out;                    // [R5]
            cap_hiz_ff <= frame_hiz;
        end
    end

    // output stage update: frame mode straight from frame, sync mode on pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= out_latch_pkg::OUT_RST;           // [R16]
            hiz_ff <= out_latch_pkg::HIZ_RST;
        end else if (mode_ff == out_latch_pkg::MODE_FRAME) begin
            if (frame_valid) begin
                out_ff <= frame_out;                    // [R3] [R4]
                hiz_ff <= frame_hiz;
            end
        end else if (sync_ff) begin
            out_ff <= cap_out_ff;                       // [R5]
            hiz_ff <= cap_hiz_ff;
        end
    end

    // per-channel tristate: enable low releases the line entirely
    assign pin_oe      = ~hiz_ff;                      // [R1] [R2]
    assign pin_o       = out_ff & ~hiz_ff;             // [R2]
    assign restart_req = restart_ff;

    // write channel: address and data accepted in either order
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign wr_fire       = aw_hold_ff && w_hold_ff && !bvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= out_latch_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= (awaddr_ff == out_latch_pkg::CTRL_OFF || awaddr_ff == out_latch_pkg::PERIOD_OFF
                               || awaddr_ff == out_latch_pkg::SHIFT_OFF)
                              ? out_latch_pkg::RESP_OKAY : out_latch_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= out_latch_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= out_latch_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                out_latch_pkg::CTRL_OFF:   rdata_ff <= {31'h0, stored_sel_ff};
                out_latch_pkg::OUTREQ_OFF: rdata_ff <= {28'h0, cap_hiz_ff[1], cap_out_ff[1], cap_hiz_ff[0], cap_out_ff[0]};
                out_latch_pkg::PERIOD_OFF: rdata_ff <= period_ff;
                out_latch_pkg::SHIFT_OFF:  rdata_ff <= shift_ff;
                out_latch_pkg::STATUS_OFF: rdata_ff <= {27'h0, mode_ff, hiz_ff[1], out_ff[1], hiz_ff[0], out_ff[0]};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= out_latch_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // frame mode follows frames within one cycle
    frame_update_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R3]
        strap_done_ff && mode_ff == out_latch_pkg::MODE_FRAME && frame_valid
        |=> out_ff == $past(frame_out) && hiz_ff == $past(frame_hiz))
        else $error("frame mode output not updated");
    // sync mode output holds between pulses
    sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R5]
        strap_done_ff && mode_ff == out_latch_pkg::MODE_SYNC && !sync_ff |=> $stable(out_ff) && $stable(hiz_ff))
        else $error("sync mode output changed without pulse");
    // sync pulse loads captured data
    sync_load_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R5]
        mode_ff == out_latch_pkg::MODE_SYNC && sync_ff |=> out_ff == $past(cap_out_ff))
        else $error("sync pulse did not load capture");
    // pulse comes shift+2 cycles after wrap
    shift_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R9]
        cyc_wrap && shift_ff == 32'h0000_0000 && period_ff > 32'h0000_0002 && $stable(shift_ff) |=> ##1 sync_ff)
        else $error("sync pulse not shifted correctly");
    // a requested high-impedance channel drops its enable and never drives high while released
    hiz_release_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R1] [R2]
        mode_ff == out_latch_pkg::MODE_FRAME && frame_valid
        |=> pin_oe == ~$past(frame_hiz) && (pin_o & ~pin_oe) == '0)
        else $error("tristate channel still drives");
    // reset state drives low
    reset_low_a: assert property (@(posedge aclk)  // [R16]
        !aresetn |=> pin_oe == '1 && pin_o == '0)
        else $error("outputs not low after reset");
    // stored-mode write does not change live mode
    mode_persist_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R15]
        strap_done_ff |=> $stable(mode_ff))
        else $error("mode changed without restart");
    // one shift for both channels: both update on the same edge
    both_channels_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R10]
        mode_ff == out_latch_pkg::MODE_SYNC && sync_ff |=> hiz_ff == $past(cap_hiz_ff))
        else $error("channels updated apart");
endmodule
`default_nettype wire

// ===== src/out_latch_pkg.sv
`default_nettype none
package out_latch_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] OUTREQ_OFF = 8'h04;
    localparam logic [7:0] PERIOD_OFF = 8'h08;
    localparam logic [7:0] SHIFT_OFF  = 8'h0C;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    // field positions
    localparam int MODE_BIT    = 0;
    localparam int RESTART_BIT = 1;
    // reset values
    localparam logic [31:0] PERIOD_RST = 32'h0000_00C8;
    localparam logic [31:0] SHIFT_RST  = 32'h0000_0000;
    localparam logic [1:0]  OUT_RST    = 2'h0;
    localparam logic [1:0]  HIZ_RST    = 2'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {
        MODE_FRAME = 1'b0,
        MODE_SYNC  = 1'b1
    } mode_t;
endpackage
`default_nettype wire

// ===== test/frame_master_model.sv
`default_nettype none
// stands in for the fieldbus master that feeds the slave controller one frame per task cycle
module frame_master_model (
    // clock
    input  wire logic       aclk,
    // frame towards the slave controller
    output logic            frame_valid,
    output logic [1:0]      frame_out,
    output logic [1:0]      frame_hiz
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       pend = 1'h0;
    logic [1:0] po   = 2'h0;
    logic [1:0] ph   = 2'h0;
    logic       fv_ff = 1'h0;
    logic [1:0] fo_ff = 2'h0;
    logic [1:0] fh_ff = 2'h0;

    // one driver per output: the registers below
    assign frame_valid = fv_ff;
    assign frame_out   = fo_ff;
    assign frame_hiz   = fh_ff;

    // data lines toggle outside a frame so a stale value can never pass for a fresh one
    always @(posedge aclk) begin
        fv_ff <= pend;
        fo_ff <= pend ? po : ~fo_ff;
        fh_ff <= pend ? ph : ~fh_ff;
    end

    // one checked frame after gap idle cycles; returns at the edge that hands it over
    task automatic send(input logic [1:0] o, input logic [1:0] h, input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        po <= o;
        ph <= h;
        pend <= 1'h1;
        @(posedge aclk);
        pend <= 1'h0;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ===== test/dual_output_latch_sync_tb.sv
`default_nettype none
module dual_output_latch_sync_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        aclk;
    logic        aresetn = 1'h0;
    logic        strap   = 1'h0;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'hF;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, frame_valid, sync_pulse, restart_req;
    logic [1:0]  bresp, rresp, frame_out, frame_hiz, pin_o, pin_oe, r;
    logic [31:0] rdata;
    int          err_count = 0, checks_done = 0, cyc = 0, rst_seen = 0, t0, n;
    // out, hiz, expected pin_o, expected pin_oe
    logic [7:0]  rows [5] = '{8'h03, 8'h47, 8'h9A, 8'hF0, 8'hE5};

    dual_output_latch_sync #(.CH(2)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .stored_mode_sync(strap), .frame_valid(frame_valid),
        .frame_out(frame_out), .frame_hiz(frame_hiz), .pin_o(pin_o), .pin_oe(pin_oe),
        .sync_pulse(sync_pulse), .restart_req(restart_req),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    frame_master_model frame_u (.aclk(aclk), .frame_valid(frame_valid), .frame_out(frame_out), .frame_hiz(frame_hiz));

    // 200 MHz clock
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end

    // cycle count, hang guard and restart pulse tally
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (restart_req === 1'h1) rst_seen <= rst_seen + 1;
        if (cyc == 10000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                rs = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask

    // read and compare data and response
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                chk(rdata, e);
                chk(32'(rresp), 32'(er));
                rready <= 1'h0;
                break;
            end
        end
    endtask

    // reset with a given stored mode; outputs sit driven low once reset is taken
    task automatic do_reset(input logic s);
        @(posedge aclk);
        aresetn <= 1'h0;
        strap <= s;
        @(posedge aclk);
        aresetn <= 1'h1;
        #1;
        chk(32'({pin_o, pin_oe}), 32'h3);
        repeat (2) @(posedge aclk);
    endtask

    task automatic wait_pulse();
        do @(posedge aclk); while (sync_pulse !== 1'h1);
    endtask

    initial begin
        do_reset(1'h0);
        // frame mode: each row lands one cycle after its frame, slower spacing each time
        foreach (rows[i]) begin
            frame_u.send(rows[i][7:6], rows[i][5:4], i);
            #1;
            chk(32'({pin_o, pin_oe}), 32'(rows[i][3:0]));
        end
        rdc(out_latch_pkg::STATUS_OFF, 32'h0D, out_latch_pkg::RESP_OKAY);
        rdc(out_latch_pkg::PERIOD_OFF, out_latch_pkg::PERIOD_RST, out_latch_pkg::RESP_OKAY);
        rdc(8'h20, 32'h0, out_latch_pkg::RESP_SLVERR);
        axw(8'h20, 32'h1, 4'hF, r);
        chk(32'(r), 32'(out_latch_pkg::RESP_SLVERR));
        // sync mode after a mid-run reset with the other stored selection
        do_reset(1'h1);
        rdc(out_latch_pkg::STATUS_OFF, 32'h10, out_latch_pkg::RESP_OKAY);
        rdc(out_latch_pkg::CTRL_OFF, 32'h1, out_latch_pkg::RESP_OKAY);
        axw(out_latch_pkg::PERIOD_OFF, 32'hFA, 4'hF, r);
        chk(32'(r), 32'(out_latch_pkg::RESP_OKAY));
        axw(out_latch_pkg::PERIOD_OFF, 32'h64, 4'h3, r);
        rdc(out_latch_pkg::PERIOD_OFF, 32'hFA, out_latch_pkg::RESP_OKAY);
        wait_pulse();
        t0 = cyc;
        wait_pulse();
        chk(cyc - t0, 32'hFA);
        frame_u.send(2'h3, 2'h0, 0);
        #1;
        chk(32'({pin_o, pin_oe}), 32'h3);
        wait_pulse();
        t0 = cyc;
        #1;
        chk(32'({pin_o, pin_oe}), 32'hF);
        axw(out_latch_pkg::SHIFT_OFF, 32'h5, 4'hF, r);
        wait_pulse();
        chk((cyc - t0) % 250, 32'h5);
        // shift beyond the period is taken unchecked and silences the pulse
        axw(out_latch_pkg::SHIFT_OFF, 32'h12C, 4'hF, r);
        n = 0;
        repeat (600) begin
            @(posedge aclk);
            if (sync_pulse !== 1'h0) n++;
        end
        chk(n, 0);
        // stored selection rewritten: restart asked for, live mode untouched
        axw(out_latch_pkg::CTRL_OFF, 32'h2, 4'hF, r);
        repeat (2) @(posedge aclk);
        chk(rst_seen, 1);
        rdc(out_latch_pkg::STATUS_OFF, 32'h15, out_latch_pkg::RESP_OKAY);
        rdc(out_latch_pkg::CTRL_OFF, 32'h0, out_latch_pkg::RESP_OKAY);
        rdc(out_latch_pkg::OUTREQ_OFF, 32'h5, out_latch_pkg::RESP_OKAY);
        print_verdict();
    end
endmodule
`default_nettype wire
